// *** bench/spi_master_chk.sv ***
/*
  port assertions for the serial bus master.
  assumes it is bound to spi_master_controller.
*/
`timescale 1ns/1ns
module spi_master_chk
  import spi_master_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        start,
  input wire logic        busy,
  input wire logic        done_irq,
  input wire logic        rx_valid,
  input wire logic        stop,
  input wire logic        select_write,
  input wire logic [4:0]  select_line_mask,
  input wire logic [4:0]  slave_select,
  input wire logic        sclk,
  input wire logic        cfg_write,
  input wire logic [2:0]  extra_slave_count,
  input wire logic [5:0]  sclk_divisor,
  input wire logic        cfg_restore,
  input wire logic [15:0] cfg_restore_value,
  input wire logic [15:0] cfg_saved
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [4:0] valid_bits;
  // mask bits honoured for the stored extra-slave count
  assign valid_bits = 5'h1F >> (3'h4 - cfg_saved[2:0]);

  a_busy_on_start:
    assert property (start && !busy |=> busy) else $error("busy missed start");
  a_irq_at_end:
    assert property ($fell(busy) |-> done_irq == cfg_saved[CFG_IRQ])
    else $error("done pulse wrong at end");
  a_irq_one_cycle:
    assert property (done_irq |-> $fell(busy) ##1 !done_irq) else $error("done pulse shape");
  a_rx_after_end:
    assert property ($fell(busy) |-> ##2 rx_valid) else $error("word late after busy");
  a_stop_clears:
    assert property (stop |=> slave_select == 5'h00) else $error("stop left a select");
  a_manual_mask:
    assert property (select_write && !cfg_saved[CFG_AUTO]
      |=> slave_select == ($past(select_line_mask) & valid_bits)) else $error("manual select");
  a_auto_idle:
    assert property (cfg_saved[CFG_AUTO] && !busy && $stable(busy) && $stable(cfg_saved)
      |-> slave_select == 5'h00) else $error("auto select while idle");
  a_sclk_idle_level:
    assert property (!busy && $stable(busy) && $stable(cfg_saved)
      |-> sclk == cfg_saved[CFG_INV]) else $error("idle clock level");
  a_cfg_restore:
    assert property (cfg_restore |=> cfg_saved == $past(cfg_restore_value))
    else $error("restore mismatch");
  a_cfg_count_clamp:
    assert property (cfg_write |=> cfg_saved[2:0] == ($past(extra_slave_count) > 3'h4 ?
      MAX_EXTRA : $past(extra_slave_count)) && cfg_saved[11:6] == $past(sclk_divisor))
    else $error("config load");
endmodule

bind spi_master_controller spi_master_chk u_chk (
  .clock(clock), .nrst(nrst), .start(start), .busy(busy), .done_irq(done_irq),
  .rx_valid(rx_valid), .stop(stop), .select_write(select_write),
  .select_line_mask(select_line_mask), .slave_select(slave_select), .sclk(sclk),
  .cfg_write(cfg_write), .extra_slave_count(extra_slave_count),
  .sclk_divisor(sclk_divisor), .cfg_restore(cfg_restore),
  .cfg_restore_value(cfg_restore_value), .cfg_saved(cfg_saved)
);

// *** bench/spi_slave_model.sv ***
/*
  loopback slave: echoes mosi on miso while selected, counts clock
  edges and frames, captures mosi on the latch edge.
  assumes clear is pulsed before each measured frame.
*/
`timescale 1ns/1ns
module spi_slave_model (
  input  wire logic        clock,
  input  wire logic        clear,
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic [4:0]  slave_select,
  input  wire logic        clock_invert,
  input  wire logic        trailing_edge_latch,
  output logic             miso,
  output logic      [7:0]  edges,
  output logic      [7:0]  frames,
  output logic      [31:0] captured
);
  logic idle_r = 1'b0;
  logic any_sel;
  assign any_sel = |slave_select;
  // released line toggles so a stale bit cannot pass
  assign miso = any_sel ? mosi : idle_r;
  always @(posedge clock) idle_r <= ~idle_r;
  always @(posedge clear) begin
    edges = 8'h00;
    frames = 8'h00;
    captured = 32'h0000_0000;
  end
  always @(posedge any_sel) frames = frames + 8'h01;
  always @(sclk) if (any_sel) begin
    edges = edges + 8'h01;
    // latch on leading edge unless trailing is chosen
    if ((sclk != clock_invert) != trailing_edge_latch) captured = {captured[30:0], mosi};
  end
endmodule

// *** bench/tb_top.sv ***
/*
  self-checking bench for the serial bus master.
  assumes the loopback slave model on the far side.
*/
`timescale 1ns/1ns
module tb_top
  import spi_master_pkg::*;
;
  logic clock = 0, nrst = 0, cfg_write = 0, low_bit_first = 0, clock_invert = 0;
  logic trailing_edge_latch = 0, done_irq_on = 0, auto_select_on = 0, cfg_restore = 0;
  logic read_edge_delay_on = 0, select_write = 0, stop = 0, start = 0, cont_write = 0;
  logic cont_enable = 0, rx_read = 0, clr = 0, busy, done_irq, sclk, mosi, miso, rx_valid;
  logic [2:0]  extra_slave_count = 0;
  logic [5:0]  sclk_divisor = 6'h08;
  logic [15:0] cfg_restore_value = 0, cfg_saved;
  logic [4:0]  select_line_mask = 0, length_code = 0, slave_select;
  logic [1:0]  start_width = 0;
  logic [31:0] tx_word = 0, rx_word, captured;
  logic [15:0] rx_word16;
  logic [7:0]  rx_word8, edges, frames;
  int          mismatches = 0, comparisons = 0;

  spi_master_controller u_dut (.clock(clock), .nrst(nrst), .cfg_write(cfg_write),
    .extra_slave_count(extra_slave_count), .low_bit_first(low_bit_first),
    .clock_invert(clock_invert), .trailing_edge_latch(trailing_edge_latch),
    .sclk_divisor(sclk_divisor), .done_irq_on(done_irq_on), .auto_select_on(auto_select_on),
    .read_edge_delay_on(read_edge_delay_on), .cfg_restore(cfg_restore),
    .cfg_restore_value(cfg_restore_value), .cfg_saved(cfg_saved), .select_write(select_write),
    .select_line_mask(select_line_mask), .stop(stop), .start(start), .start_width(start_width),
    .length_code(length_code), .tx_word(tx_word), .cont_write(cont_write),
    .cont_enable(cont_enable), .rx_read(rx_read), .rx_word(rx_word), .rx_word16(rx_word16),
    .rx_word8(rx_word8), .rx_valid(rx_valid), .busy(busy), .done_irq(done_irq), .sclk(sclk),
    .mosi(mosi), .miso(miso), .slave_select(slave_select));
  spi_slave_model u_slave (.clock(clock), .clear(clr), .sclk(sclk), .mosi(mosi),
    .slave_select(slave_select), .clock_invert(clock_invert),
    .trailing_edge_latch(trailing_edge_latch), .miso(miso), .edges(edges), .frames(frames),
    .captured(captured));

  always #4 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clock);
    s = 0;
  endtask
  task automatic cfg(input logic [2:0] n, input logic lb, inv, tr, irq, au);
    extra_slave_count = n;
    low_bit_first = lb;
    clock_invert = inv;
    trailing_edge_latch = tr;
    done_irq_on = irq;
    auto_select_on = au;
    pulse(cfg_write);
  endtask
  task automatic sel(input logic [4:0] m);
    select_line_mask = m;
    pulse(select_write);
  endtask
  task automatic xfer(input logic [1:0] w, input logic [4:0] code, input logic [31:0] tx,
                      output logic irq);
    int n;
    n = 0;
    start_width = w;
    length_code = code;
    tx_word = tx;
    clr = 1;
    pulse(start);
    clr = 0;
    check(busy, 1, "busy");
    while (busy === 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    check(n < 4000, 1, "transfer wait");
    irq = done_irq;
    repeat (2) @(negedge clock);
    check(rx_valid, 1, "rx valid");
  endtask
  task automatic wait_done(input logic [7:0] n);
    int k;
    k = 0;
    while (!(frames === n && busy === 1'b0) && k < 3000) begin
      @(negedge clock);
      k++;
    end
    check(k < 3000, 1, "frame wait");
  endtask

  task automatic t_reset();
    check({busy, rx_valid, sclk, slave_select}, 0, "reset outputs");
    check(cfg_saved, CFG_RESET, "reset config");
    $display("test reset done");
  endtask
  task automatic t_config();
    cfg(3'h7, 1, 0, 1, 1, 0);
    check(cfg_saved, 16'h122C, "config fields");
    cfg_restore_value = 16'h2A5B;
    pulse(cfg_restore);
    check(cfg_saved, 16'h2A5B, "restore");
    $display("test config done");
  endtask
  task automatic t_select();
    cfg(3'h2, 0, 0, 0, 0, 0);
    sel(5'h1F);
    check(slave_select, 5'h07, "manual mask");
    pulse(stop);
    check(slave_select, 5'h00, "stop");
    cfg(3'h0, 0, 0, 0, 0, 1);
    sel(5'h01);
    check(slave_select, 5'h00, "auto idle");
    $display("test select done");
  endtask
  task automatic t_var();
    logic [4:0]  codes [4] = '{5'h00, 5'h07, 5'h1F, 5'h0C};
    logic [31:0] tx, exp;
    logic        irq;
    for (int i = 0; i < 8; i++) begin
      tx = 32'hC35A_96E1 ^ i;
      cfg(3'h0, i[2], i[1], i[0], i != 3, 1);
      sel(5'h01);
      xfer(WIDTH_VAR, codes[i % 4], tx, irq);
      exp = 0;
      for (int b = 0; b <= codes[i % 4]; b++) exp[i[2] ? codes[i % 4] - b : b] = tx[b];
      check(edges, 2 * (codes[i % 4] + 1), "clock edges");
      check(captured, exp, "wire order");
      check(rx_word, tx & (32'hFFFF_FFFF >> (31 - codes[i % 4])), "rx word");
      check(irq, i != 3, "done pulse");
      pulse(rx_read);
      check(rx_valid, 0, "popped");
    end
    $display("test variable done");
  endtask
  task automatic t_fixed();
    logic [31:0] tx;
    logic        irq;
    tx = 32'hA5C3_9E17;
    read_edge_delay_on = 1;
    cfg(3'h0, 0, 1, 0, 1, 1);
    for (int j = 1; j < 4; j++) begin
      xfer(j[1:0], 5'h00, tx, irq);
      check(edges, 8 << j, "fixed length");
      if (j == 1) check(rx_word8, tx[7:0], "rx 8");
      if (j == 2) check(rx_word16, tx[15:0], "rx 16");
      if (j == 3) check(rx_word, tx, "rx 32");
      pulse(rx_read);
    end
    $display("test fixed done");
  endtask
  task automatic t_fifo();
    logic irq;
    for (int k = 0; k < FIFO_DEPTH; k++) xfer(WIDTH_8, 5'h00, k * 17, irq);
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      check(rx_word8, k * 17, "fifo order");
      pulse(rx_read);
      @(negedge clock);
    end
    check(rx_valid, 0, "fifo empty");
    $display("test fifo done");
  endtask
  task automatic t_cont();
    clr = 1;
    length_code = 5'h09;
    cont_enable = 1;
    pulse(cont_write);
    clr = 0;
    wait_done(1);
    repeat (400) @(negedge clock);
    check(frames, 1, "held for read");
    pulse(rx_read);
    wait_done(2);
    cont_enable = 0;
    pulse(cont_write);
    repeat (2) begin
      repeat (800) @(negedge clock);
      pulse(rx_read);
    end
    repeat (800) @(negedge clock);
    check(frames, 3, "one more then stop");
    $display("test continuous done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    results();
  end
  initial begin
    repeat (8) @(negedge clock);
    nrst = 1;
    t_reset();
    t_config();
    t_select();
    t_var();
    t_fixed();
    t_fifo();
    t_cont();
    results();
  end
endmodule

// *** core/spi_fifo.sv ***
/*
  flop based first-in first-out buffer with valid/ready on both sides.
  assumes a single clock; width and depth shape the storage.
*/
`timescale 1ns/1ns
module spi_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t f_r;
  fifo_state_t f_nxt;
  logic        push;
  logic        pop;

  always_comb begin
    push  = in_valid && (f_r.cnt != (AW+1)'(DEPTH));
    pop   = out_ready && (f_r.cnt != '0);
    f_nxt = f_r;
    if (push) begin
      f_nxt.mem[f_r.wp] = in_data;
      f_nxt.wp          = f_r.wp + 1'b1;
    end
    if (pop) begin
      f_nxt.rp = f_r.rp + 1'b1;
    end
    if (push && !pop) begin
      f_nxt.cnt = f_r.cnt + 1'b1;
    end else if (pop && !push) begin
      f_nxt.cnt = f_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign in_ready  = (f_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (f_r.cnt != '0);
  assign out_data  = f_r.mem[f_r.rp];

endmodule

// *** core/spi_master_controller.sv ***
/*
  serial peripheral bus master: clock divider, shifter, slave selects,
  continuous receive pacing and a received-word FIFO.
  assumes all control bits are plain ports from the host on the same
  clock, and the slave data input is an asynchronous pin.
*/
//
// Behaviour
// - manual select drives mask at once; auto select only during a transfer
// - only mask bits 0 up to the extra-slave count are honoured
// - stop clears every select line, same as writing mask zero
// - length code is bits minus one, 0 gives 1 bit, 31 gives 32
// - received bits appear right-aligned in a 32-bit word
// - completion interrupt raised per finished transfer when enabled
// - busy reads true while a transfer is in progress
// - fixed 8, 16 and 32 bit starts with matching-width read data
// - continuous mode holds off the next transfer until word is read
// - enabling continuous mode starts transfers by itself
// - disabling continuous mode performs one more transfer then stops
// - reading the word in continuous mode starts the next transfer
// - read-edge delay moves sampling to the other serial clock edge, half a period later or earlier
// - whole configuration is readable as one value and restorable
// - serial clock is system clock over twice divisor; 0 gives the same rate as 1
// - invert sets idle polarity, trailing selects latch edge, modes 0-3
// - extra-slave count 0 to 4, larger values truncate to 4
// - bit order selects low or high bit first
`timescale 1ns/1ns
module spi_master_controller
  import spi_master_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        cfg_write,
  input  wire logic [2:0]  extra_slave_count,
  input  wire logic        low_bit_first,
  input  wire logic        clock_invert,
  input  wire logic        trailing_edge_latch,
  input  wire logic [5:0]  sclk_divisor,
  input  wire logic        done_irq_on,
  input  wire logic        auto_select_on,
  input  wire logic        read_edge_delay_on,
  input  wire logic        cfg_restore,
  input  wire logic [15:0] cfg_restore_value,
  output logic      [15:0] cfg_saved,
  input  wire logic        select_write,
  input  wire logic [4:0]  select_line_mask,
  input  wire logic        stop,
  input  wire logic        start,
  input  wire logic [1:0]  start_width,
  input  wire logic [4:0]  length_code,
  input  wire logic [31:0] tx_word,
  input  wire logic        cont_write,
  input  wire logic        cont_enable,
  input  wire logic        rx_read,
  output logic      [31:0] rx_word,
  output logic      [15:0] rx_word16,
  output logic      [7:0]  rx_word8,
  output logic             rx_valid,
  output logic             busy,
  output logic             done_irq,
  output logic             sclk,
  output logic             mosi,
  input  wire logic        miso,
  output logic      [4:0]  slave_select
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg;
    logic [4:0]  mask;
    xfer_state_t st;
    logic [5:0]  div_cnt;
    logic [4:0]  len;
    logic [5:0]  bit_cnt;
    logic [31:0] tx_sh;
    logic [31:0] rx_sh;
    logic        cont;
    logic        cont_last;
    logic        wait_read;
    logic        sclk;
    logic        mosi;
    logic [4:0]  ss;
    logic        busy;
    logic        irq;
  } ctl_state_t;

  ctl_state_t c_r;
  ctl_state_t c_nxt;
  logic       miso_s;
  logic       fifo_in_ready;
  logic       fifo_push;
  logic [31:0] rx_aligned;
  logic [31:0] fifo_out;
  logic       fifo_valid;

  function automatic logic [4:0] valid_bits(input logic [2:0] cnt);
    logic [2:0] c;
    c = (cnt > MAX_EXTRA) ? MAX_EXTRA : cnt;
    valid_bits = 5'(({1'b0, 5'h1F} >> (3'h4 - c)) >> 1);
    valid_bits = 5'h1F >> (3'h4 - c);
  endfunction

  function automatic logic [4:0] width_code(input logic [1:0] w, input logic [4:0] lc);
    case (w)
      WIDTH_8:  width_code = LEN_CODE_8;
      WIDTH_16: width_code = LEN_CODE_16;
      WIDTH_32: width_code = LEN_CODE_32;
      default:  width_code = lc;
    endcase
  endfunction

  spi_sync3 u_sync (
    .clock (clock),
    .nrst  (nrst),
    .pin   (miso),
    .level (miso_s)
  );

  // ------------------------------------------------------------
  // received word buffer
  // ------------------------------------------------------------
  spi_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_data   (rx_aligned),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (rx_read)
  );

  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  logic        lowb;
  logic        inv;
  logic        trail;
  logic        dre;
  logic [5:0]  divv;
  logic        tick;
  logic        sample_lead;
  logic        go;
  logic [4:0]  go_len;
  logic [2:0]  cnt_sat;

  always_comb begin
    c_nxt       = c_r;
    c_nxt.irq   = 1'b0;
    fifo_push   = 1'b0;
    lowb        = c_r.cfg[CFG_LOWB];
    inv         = c_r.cfg[CFG_INV];
    trail       = c_r.cfg[CFG_TRAIL];
    dre         = c_r.cfg[CFG_DRE];
    divv        = c_r.cfg[CFG_DIV_LSB +: DIV_W];
    tick        = (divv == 6'h00) || (c_r.div_cnt == divv - 6'h01);
    // data latched on the leading edge unless trailing; read-edge delay swaps to the other edge
    sample_lead = ~(trail ^ dre);
    rx_aligned  = lowb ? (c_r.rx_sh >> (6'd31 - {1'b0, c_r.len}))
                       : c_r.rx_sh;
    go          = 1'b0;
    go_len      = c_r.len;
    cnt_sat     = (extra_slave_count > MAX_EXTRA) ? MAX_EXTRA : extra_slave_count;

    if (cfg_write) begin
      c_nxt.cfg = {1'b0, read_edge_delay_on, auto_select_on, done_irq_on, sclk_divisor,
                   clock_invert, trailing_edge_latch, low_bit_first, cnt_sat};
      c_nxt.cfg[CFG_INV]   = clock_invert;
      c_nxt.cfg[CFG_TRAIL] = trailing_edge_latch;
    end else if (cfg_restore) begin
      c_nxt.cfg = cfg_restore_value;
    end
    if (stop) begin
      c_nxt.mask = SEL_RESET;
    end else if (select_write) begin
      c_nxt.mask = select_line_mask & valid_bits(c_r.cfg[2:0]);
    end

    if (cont_write) begin
      c_nxt.cont = cont_enable;
      c_nxt.len  = length_code;
      if (!cont_enable && c_r.cont) begin
        c_nxt.cont_last = 1'b1;
        c_nxt.wait_read = 1'b0;
      end
    end

    case (c_r.st)
      ST_IDLE: begin
        if (start) begin
          go     = 1'b1;
          go_len = width_code(start_width, length_code);
        end else if (cont_write && cont_enable && !c_r.cont) begin
          go     = 1'b1;
          go_len = length_code;
        end else if ((c_r.cont && !c_r.wait_read) || c_r.cont_last) begin
          go = fifo_in_ready;
          c_nxt.cont_last = c_r.cont_last && !fifo_in_ready;
        end
        if (go) begin
          c_nxt.st      = ST_LEAD;
          c_nxt.len     = go_len;
          c_nxt.bit_cnt = 6'h00;
          c_nxt.div_cnt = 6'h00;
          c_nxt.rx_sh   = RX_RESET;
          c_nxt.busy    = 1'b1;
          // host right-aligns data; high first starts from the top used bit
          c_nxt.tx_sh   = lowb ? tx_word : (tx_word << (5'd31 - go_len));
          c_nxt.mosi    = lowb ? tx_word[0] : tx_word[go_len];
        end
      end
      ST_LEAD: begin
        c_nxt.div_cnt = tick ? 6'h00 : c_r.div_cnt + 6'h01;
        if (tick) begin
          c_nxt.sclk = ~inv;
          c_nxt.st   = ST_TRAIL;
          // trailing latch: later bits leave on the leading edge
          if (trail && c_r.bit_cnt != 6'h00) begin
            c_nxt.tx_sh = lowb ? (c_r.tx_sh >> 1) : (c_r.tx_sh << 1);
            c_nxt.mosi  = lowb ? c_r.tx_sh[1] : c_r.tx_sh[30];
          end
          if (sample_lead) begin
            c_nxt.rx_sh = lowb ? {miso_s, c_r.rx_sh[31:1]} : {c_r.rx_sh[30:0], miso_s};
          end
        end
      end
      ST_TRAIL: begin
        c_nxt.div_cnt = tick ? 6'h00 : c_r.div_cnt + 6'h01;
        if (tick) begin
          c_nxt.sclk    = inv;
          c_nxt.bit_cnt = c_r.bit_cnt + 6'h01;
          if (!sample_lead) begin
            c_nxt.rx_sh = lowb ? {miso_s, c_r.rx_sh[31:1]} : {c_r.rx_sh[30:0], miso_s};
          end
          // leading latch: next bit leaves on the trailing edge
          if (!trail) begin
            c_nxt.tx_sh = lowb ? (c_r.tx_sh >> 1) : (c_r.tx_sh << 1);
            c_nxt.mosi  = lowb ? c_r.tx_sh[1] : c_r.tx_sh[30];
          end
          c_nxt.st    = (c_r.bit_cnt == {1'b0, c_r.len}) ? ST_DONE : ST_LEAD;
        end
      end
      ST_DONE: begin
        fifo_push       = 1'b1;
        c_nxt.busy      = 1'b0;
        c_nxt.irq       = c_r.cfg[CFG_IRQ];
        c_nxt.wait_read = c_r.cont && !(cont_write && !cont_enable);
        c_nxt.st        = ST_IDLE;
      end
      default: c_nxt.st = ST_IDLE;
    endcase

    if (c_r.wait_read && rx_read) begin
      c_nxt.wait_read = 1'b0;
    end
    if (c_r.st == ST_IDLE && !go) begin
      c_nxt.sclk = c_nxt.cfg[CFG_INV];
    end
    // manual selects follow the mask, auto only while a frame runs
    if (c_nxt.cfg[CFG_AUTO]) begin
      c_nxt.ss = (c_nxt.st != ST_IDLE) ? c_nxt.mask : SEL_RESET;
    end else begin
      c_nxt.ss = c_nxt.mask;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rx;
    logic        vld;
  } out_state_t;

  out_state_t o_r;
  out_state_t o_nxt;

  always_comb begin
    o_nxt     = o_r;
    o_nxt.rx  = fifo_out;
    o_nxt.vld = fifo_valid && !(rx_read && o_r.vld);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      o_r <= '0;
    end else begin
      o_r <= o_nxt;
    end
  end

  assign cfg_saved    = c_r.cfg;
  assign rx_word      = o_r.rx;
  assign rx_word16    = o_r.rx[15:0];
  assign rx_word8     = o_r.rx[7:0];
  assign rx_valid     = o_r.vld;
  assign busy         = c_r.busy;
  assign done_irq     = c_r.irq;
  assign sclk         = c_r.sclk;
  assign mosi         = c_r.mosi;
  assign slave_select = c_r.ss;

endmodule

// *** core/spi_master_pkg.sv ***
/*
  constants and types shared by the serial peripheral bus master.
  assumes a 125 MHz system clock; no bus, all controls are plain ports.
*/
package spi_master_pkg;

  // ------------------------------------------------------------
  // widths and limits
  // ------------------------------------------------------------
  localparam int          DATA_W        = 32;
  localparam int          SEL_W         = 5;
  localparam int          LEN_W         = 5;
  localparam int          DIV_W         = 6;
  localparam int          CFG_W         = 16;
  localparam logic [2:0]  MAX_EXTRA     = 3'h4;
  localparam int          FIFO_DEPTH    = 16;

  // ------------------------------------------------------------
  // fixed transfer length codes (legacy variant)
  // ------------------------------------------------------------
  localparam logic [4:0]  LEN_CODE_8    = 5'h07;
  localparam logic [4:0]  LEN_CODE_16   = 5'h0F;
  localparam logic [4:0]  LEN_CODE_32   = 5'h1F;
  localparam logic [1:0]  WIDTH_VAR     = 2'h0;
  localparam logic [1:0]  WIDTH_8       = 2'h1;
  localparam logic [1:0]  WIDTH_16      = 2'h2;
  localparam logic [1:0]  WIDTH_32      = 2'h3;

  // ------------------------------------------------------------
  // saved configuration field positions
  // ------------------------------------------------------------
  localparam int          CFG_EXTRA_LSB = 0;
  localparam int          CFG_LOWB      = 3;
  localparam int          CFG_INV       = 4;
  localparam int          CFG_TRAIL     = 5;
  localparam int          CFG_DIV_LSB   = 6;
  localparam int          CFG_IRQ       = 12;
  localparam int          CFG_AUTO      = 13;
  localparam int          CFG_DRE       = 14;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CFG_RESET     = 16'h0000;
  localparam logic [4:0]  SEL_RESET     = 5'h00;
  localparam logic [31:0] RX_RESET      = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_TRAIL = 2'b10,
    ST_DONE = 2'b11
  } xfer_state_t;

endpackage

// *** core/spi_sync3.sv ***
/*
  three flip-flop input synchroniser; a change is taken once the
  second and third stages agree. assumes an asynchronous input pin.
*/
`timescale 1ns/1ns
module spi_sync3 (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level
);

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.sh = {s_r.sh[1:0], pin};
    if (s_r.sh[1] == s_r.sh[2]) begin
      s_nxt.lvl = s_r.sh[2];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.lvl;

endmodule
